// file: rtl/hirp_cfg.svh
// Constants for the haptic I2C register port: addresses and last bit index.
// Assumes the includer is a design file of the same block.
//
// Operation
// [R1] Answer fixed 7-bit address 0x5A: 0xB4 write, 0xB5 read.
// [R2] Every register supports single-byte and multi-byte write and read.
// [R3] Multi-byte read returns bytes from selected register while controller acks.
// [R4] Write: first byte is index, following bytes go to consecutive registers.
// [R5] Controller writes: start, address with bit 0, index, data, stop.
// [R6] Acknowledge matching address and the register index byte.
// [R7] Acknowledge every received write data byte; the port not-acks a byte while the write buffer is full.
// [R8] Controller reads: write index, repeated start, address with read bit.
// [R9] After read address ack, send register selected by preceding write.
// [R10] Single-byte read: controller answers data with not-ack, then stop.
// [R11] Multi-byte read: controller acks all but the last byte.
// [R12] Bytes travel MSB first; receiver acknowledges each byte.
// [R13] With broadcast enable set, also answer 7-bit address 0x58.
// [R14] Register access works in standby and active states.
// [R15] Unmatched address: release SDA, ignore until next start.
// [R16] Release SDA in ack slot of sent byte; stop after not-ack.
`ifndef HIRP_CFG_SVH
`define HIRP_CFG_SVH
`define HIRP_ADDR_FIXED 7'h5a
`define HIRP_ADDR_BCAST 7'h58
`define HIRP_BIT_LAST   3'h7
`endif

// file: rtl/hirp_pkg.sv
// Types of the haptic I2C register port.
// Assumes hirp_cfg.svh is compiled alongside.
package hirp_pkg;
   typedef enum logic [2:0] {
      HIRP_IDLE  = 3'b000,
      HIRP_ADDR  = 3'b001,
      HIRP_WACK  = 3'b010,
      HIRP_WBYTE = 3'b011,
      HIRP_RBYTE = 3'b100,
      HIRP_RACK  = 3'b101
   } hirp_state_e;
   typedef logic [7:0] hirp_byte_t;
endpackage

// file: rtl/hirp_port.sv
// I2C target register port: SCL and SDA are sampled on clk, edges found.
// Assumes an external register file with same-cycle read data and a host
// side that drains writes through a two-entry buffer (wr_valid/wr_ready).
`include "hirp_cfg.svh"
module hirp_port (
   // Clock and reset
   input  wire logic               clk,
   input  wire logic               reset_n,
   // Bus pins
   input  wire logic               scl_in,
   input  wire logic               sda_in,
   output logic                    sda_out,
   output logic                    sda_oe,
   // Control
   input  wire logic               broadcast_address_enable,
   // Register write stream
   output logic                    wr_valid,
   input  wire logic               wr_ready,
   output hirp_pkg::hirp_byte_t    wr_index,
   output hirp_pkg::hirp_byte_t    wr_data,
   // Register read
   output hirp_pkg::hirp_byte_t    rd_index,
   input  wire hirp_pkg::hirp_byte_t rd_data
);
   import hirp_pkg::*;

   typedef struct packed {
      logic [1:0]  rst;
      logic [1:0]  scl_s;
      logic [1:0]  sda_s;
      logic        scl_d;
      logic        sda_d;
      hirp_state_e st;
      logic [2:0]  bit_n;
      hirp_byte_t  sh;
      logic        rw;
      logic        got_idx;
      logic        ack_ok;
      hirp_byte_t  idx;
      logic        drive_low;
      logic        bv0;
      logic        bv1;
      logic [15:0] b0;
      logic [15:0] b1;
   } hirp_s;

   hirp_s q_r;
   hirp_s q_nxt;
   logic  rst_n;
   logic  scl_rise;
   logic  scl_fall;
   logic  start_c;
   logic  stop_c;
   logic  push;
   logic  pop;

   // ==================================================================
   // Buffer helper: whether the two-entry buffer can accept a byte
   function automatic logic hirp_room(input logic v0, input logic v1);
      return !(v0 && v1);
   endfunction

   assign rst_n    = q_r.rst[1];
   assign scl_rise = q_r.scl_s[1] && !q_r.scl_d;
   assign scl_fall = !q_r.scl_s[1] && q_r.scl_d;
   assign start_c  = q_r.scl_s[1] && q_r.scl_d && q_r.sda_d && !q_r.sda_s[1];
   assign stop_c   = q_r.scl_s[1] && q_r.scl_d && !q_r.sda_d && q_r.sda_s[1];
   assign pop      = q_r.bv0 && wr_ready;

   assign sda_out  = 1'b0;
   assign sda_oe   = q_r.drive_low;
   assign wr_valid = q_r.bv0;
   assign wr_index = q_r.b0[15:8];
   assign wr_data  = q_r.b0[7:0];
   assign rd_index = q_r.idx;

   // ==================================================================
   // Next state
   always_comb begin
      q_nxt       = q_r;
      push        = 1'b0;
      q_nxt.rst   = {q_r.rst[0], 1'b1};
      q_nxt.scl_s = {q_r.scl_s[0], scl_in};
      q_nxt.sda_s = {q_r.sda_s[0], sda_in};
      q_nxt.scl_d = q_r.scl_s[1];
      q_nxt.sda_d = q_r.sda_s[1];
      // Port runs whatever the device power state; no gating here R14
      if (start_c) begin
         q_nxt.st        = HIRP_ADDR;
         q_nxt.bit_n     = 3'h0;
         q_nxt.got_idx   = 1'b0;
         q_nxt.ack_ok    = 1'b0;
         q_nxt.drive_low = 1'b0;
      end else if (stop_c) begin
         q_nxt.st        = HIRP_IDLE;
         q_nxt.drive_low = 1'b0;
      end else begin
         unique case (q_r.st)
            HIRP_IDLE: begin
               q_nxt.drive_low = 1'b0; // R15
            end
            HIRP_ADDR, HIRP_WBYTE: begin
               // A bit taken since the last byte end marks the next fall with
               // bit_n at zero as the eighth; the fall right after a start is not
               if (scl_rise) begin
                  q_nxt.sh     = {q_r.sh[6:0], q_r.sda_s[1]}; // R12
                  q_nxt.bit_n  = q_r.bit_n + 3'h1;
                  q_nxt.ack_ok = 1'b1;
               end
               if (scl_fall && q_r.bit_n == 3'h0 && q_r.ack_ok) begin
                  q_nxt.ack_ok = 1'b0;
                  if (q_r.st == HIRP_ADDR) begin
                     if (q_r.sh[7:1] == `HIRP_ADDR_FIXED // R1
                         || (broadcast_address_enable
                             && q_r.sh[7:1] == `HIRP_ADDR_BCAST)) begin // R13
                        q_nxt.rw        = q_r.sh[0];
                        q_nxt.drive_low = 1'b1; // R6
                        q_nxt.st        = HIRP_WACK;
                     end else begin
                        q_nxt.st = HIRP_IDLE; // R15
                     end
                  end else if (!q_r.got_idx) begin
                     q_nxt.idx       = q_r.sh;
                     q_nxt.got_idx   = 1'b1;
                     q_nxt.drive_low = 1'b1; // R6
                     q_nxt.st        = HIRP_WACK;
                  end else if (hirp_room(q_r.bv0, q_r.bv1)) begin
                     push            = 1'b1;
                     q_nxt.drive_low = 1'b1; // R7
                     q_nxt.st        = HIRP_WACK;
                  end else begin
                     // Buffer full: not-ack rather than lose the byte
                     q_nxt.st = HIRP_IDLE;
                  end
               end
            end
            HIRP_WACK: begin
               if (scl_fall) begin
                  q_nxt.drive_low = 1'b0;
                  q_nxt.bit_n     = 3'h0;
                  if (q_r.rw) begin
                     q_nxt.sh        = rd_data; // R9
                     q_nxt.drive_low = !rd_data[7]; // R12
                     q_nxt.st        = HIRP_RBYTE;
                  end else begin
                     q_nxt.st = HIRP_WBYTE;
                  end
               end
            end
            HIRP_RBYTE: begin
               if (scl_fall) begin
                  if (q_r.bit_n == `HIRP_BIT_LAST) begin
                     q_nxt.drive_low = 1'b0; // R16
                     q_nxt.idx       = q_r.idx + 8'h01; // R3
                     q_nxt.st        = HIRP_RACK;
                  end else begin
                     q_nxt.sh        = {q_r.sh[6:0], 1'b0};
                     q_nxt.drive_low = !q_r.sh[6]; // R12
                     q_nxt.bit_n     = q_r.bit_n + 3'h1;
                  end
               end
            end
            HIRP_RACK: begin
               if (scl_rise) begin
                  q_nxt.ack_ok = !q_r.sda_s[1];
               end
               if (scl_fall) begin
                  if (q_r.ack_ok) begin
                     q_nxt.sh        = rd_data; // R3
                     q_nxt.drive_low = !rd_data[7];
                     q_nxt.bit_n     = 3'h0;
                     q_nxt.st        = HIRP_RBYTE;
                  end else begin
                     q_nxt.st = HIRP_IDLE; // R16
                  end
                  q_nxt.ack_ok = 1'b0;
               end
            end
            default: q_nxt.st = HIRP_IDLE;
         endcase
      end
      // Two-entry write buffer; index advances per data byte R4
      if (pop) begin
         q_nxt.bv0 = q_r.bv1;
         q_nxt.b0  = q_r.b1;
         q_nxt.bv1 = 1'b0;
      end
      if (push) begin
         q_nxt.idx = q_r.idx + 8'h01; // R4
         if (pop ? !q_r.bv1 : !q_r.bv0) begin
            q_nxt.bv0 = 1'b1;
            q_nxt.b0  = {q_r.idx, q_r.sh};
         end else begin
            q_nxt.bv1 = 1'b1;
            q_nxt.b1  = {q_r.idx, q_r.sh};
         end
      end
   end

   // ==================================================================
   // Registers; reset copy comes from the first two flops
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         q_r       <= '0;
         q_r.scl_s <= 2'h3;
         q_r.sda_s <= 2'h3;
         q_r.scl_d <= 1'b1;
         q_r.sda_d <= 1'b1;
      end else if (!rst_n) begin
         q_r.rst   <= q_nxt.rst;
         q_r.scl_s <= q_nxt.scl_s;
         q_r.sda_s <= q_nxt.sda_s;
         q_r.scl_d <= q_nxt.scl_d;
         q_r.sda_d <= q_nxt.sda_d;
      end else begin
         q_r <= q_nxt;
      end
   end

   // ==================================================================
   // Checks
   a_addr_ack_match: assert property (@(posedge clk) disable iff (!rst_n)
      (q_r.st == HIRP_ADDR && q_nxt.st == HIRP_WACK && !start_c)
      |-> (q_r.sh[7:1] == `HIRP_ADDR_FIXED
           || (broadcast_address_enable && q_r.sh[7:1] == `HIRP_ADDR_BCAST)))
      else $error("address acked without match"); // R1
   a_bcast_gated: assert property (@(posedge clk) disable iff (!rst_n)
      (q_r.st == HIRP_ADDR && q_nxt.st == HIRP_WACK && !broadcast_address_enable)
      |-> q_r.sh[7:1] != `HIRP_ADDR_BCAST)
      else $error("broadcast acked while disabled"); // R13
   a_idle_release: assert property (@(posedge clk) disable iff (!rst_n)
      q_r.st == HIRP_IDLE |=> !sda_oe)
      else $error("sda driven while ignoring"); // R15
   a_rack_release: assert property (@(posedge clk) disable iff (!rst_n)
      q_r.st == HIRP_RACK |-> !sda_oe)
      else $error("sda driven in ack slot of read"); // R16
   a_wack_drive: assert property (@(posedge clk) disable iff (!rst_n)
      (q_r.st == HIRP_WACK && !q_r.rw) |-> sda_oe)
      else $error("write ack not driven"); // R7
   a_idx_step: assert property (@(posedge clk) disable iff (!rst_n)
      push |=> q_r.idx == $past(q_r.idx) + 8'h01)
      else $error("index did not advance"); // R4
   a_buf_keep: assert property (@(posedge clk) disable iff (!rst_n)
      (wr_valid && !wr_ready) |=> (wr_valid && $stable(wr_data) && $stable(wr_index)))
      else $error("stalled write word changed"); // R2
   a_read_msb: assert property (@(posedge clk) disable iff (!rst_n)
      (q_r.st == HIRP_WACK && q_r.rw && scl_fall && !start_c && !stop_c)
      |=> sda_oe == !$past(rd_data[7]))
      else $error("read msb wrong"); // R9
endmodule

// file: verification/hirp_host_model.sv
// I2C controller model: drives SCL and pulls SDA low, one bit per 160 ns.
// Assumes the bench resolves SDA with a pull-up and feeds the wire back.
module hirp_host_model (
   // Clock
   input  wire logic clk,
   // Bus
   output logic      scl,
   output logic      sda_pull,
   input  wire logic sda_wire
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      scl      = 1'b1;
      sda_pull = 1'b0;
   end
   task automatic qtr();
      repeat (4) @(posedge clk);
   endtask
   // SDA moves only while SCL is low, a quarter away from either edge
   task automatic bit_io(input logic b, output logic r);
      sda_pull <= !b;
      qtr();
      scl <= 1'b1;
      qtr();
      @(negedge clk);
      r = sda_wire;
      qtr();
      scl <= 1'b0;
      qtr();
   endtask
   // Also serves as repeated start, SCL being low after an ack slot
   task automatic bus_start();
      sda_pull <= 1'b0;
      qtr();
      scl <= 1'b1;
      qtr();
      sda_pull <= 1'b1;
      qtr();
      scl <= 1'b0;
      qtr();
   endtask
   // SCL then stands high until the next frame
   task automatic bus_stop();
      sda_pull <= 1'b1;
      qtr();
      scl <= 1'b1;
      qtr();
      sda_pull <= 1'b0;
      qtr();
   endtask
   // Ack bit low acknowledges; tx of all ones leaves SDA to the target
   task automatic xfer(input logic [7:0] tx, input logic ack_in,
                       output logic [7:0] rx, output logic ack_seen);
      for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
      bit_io(ack_in, ack_seen);
   endtask
endmodule

// file: verification/haptic_i2c_register_port_bench.sv
// Self-checking bench of the haptic I2C register port.
// Assumes rtl/ is compiled first and the host model beside it.
module haptic_i2c_register_port_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import hirp_pkg::*;
   logic clk = 1'b0, reset_n = 1'b0, bcast = 1'b0, wr_ready = 1'b0, stall = 1'b0;
   logic scl, sda_pull, sda_out, sda_oe, wr_valid, sda_wire;
   hirp_byte_t wr_index, wr_data, rd_index, rd_data;
   hirp_byte_t regs [256];
   hirp_byte_t mdl [256];
   logic [15:0] exp_q [$];
   logic [15:0] rnd = 16'he4e5;
   int fail_count = 0, total_checks = 0;
   // ==========================================
   // Environment
   always #5 clk = ~clk;
   assign sda_wire = !(sda_oe && !sda_out) && !sda_pull;
   assign rd_data = regs[rd_index];
   hirp_port dut (.clk(clk), .reset_n(reset_n), .scl_in(scl), .sda_in(sda_wire),
      .sda_out(sda_out), .sda_oe(sda_oe), .broadcast_address_enable(bcast),
      .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_index(wr_index),
      .wr_data(wr_data), .rd_index(rd_index), .rd_data(rd_data));
   hirp_host_model host (.clk(clk), .scl(scl), .sda_pull(sda_pull), .sda_wire(sda_wire));
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   // Register a byte lands in: the index wraps past the last register
   function automatic hirp_byte_t reg_at(input hirp_byte_t base, input int k);
      return base + k[7:0];
   endfunction
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Register file drained at random pace; each word checked in order
   always @(posedge clk) begin
      rnd <= lfsr(rnd);
      wr_ready <= !stall && rnd[0];
      if (wr_valid && wr_ready) begin
         regs[wr_index] <= wr_data;
         check({wr_index, wr_data}, exp_q.size() ? exp_q.pop_front() : 16'hxxxx);
      end
   end
   // ==========================================
   // Transfers
   task automatic drain();
      for (int t = 0; t < 200 && exp_q.size() != 0; t++) @(posedge clk);
      check(16'(exp_q.size()), 16'h0000);
   endtask
   // Bytes from na on expect no ack; ok says whether the address answers
   task automatic wr_seq(input logic [6:0] a, input hirp_byte_t idx, input int n,
                         input int na, input logic ok);
      logic [7:0] rx;
      logic ak;
      hirp_byte_t d;
      host.bus_start();
      host.xfer({a, 1'b0}, 1'b1, rx, ak);
      check(16'(ak), 16'(!ok));
      host.xfer(idx, 1'b1, rx, ak);
      check(16'(ak), 16'(!ok));
      for (int k = 0; k < n && ok; k++) begin
         d = rnd[7:0];
         // Expect the word before the byte goes out: it may drain during the ack slot
         if (k < na) begin
            exp_q.push_back({reg_at(idx, k), d});
            mdl[reg_at(idx, k)] = d;
         end
         host.xfer(d, 1'b1, rx, ak);
         check(16'(ak), 16'(k >= na));
         if (k >= na) break;
      end
      host.bus_stop();
      if (!stall) drain();
   endtask
   task automatic rd_seq(input hirp_byte_t idx, input int n);
      logic [7:0] rx;
      logic ak;
      host.bus_start();
      host.xfer(8'hb4, 1'b1, rx, ak);
      host.xfer(idx, 1'b1, rx, ak);
      check(16'(ak), 16'h0000);
      host.bus_start();
      host.xfer(8'hb5, 1'b1, rx, ak);
      check(16'(ak), 16'h0000);
      for (int k = 0; k < n; k++) begin
         host.xfer(8'hff, k == n - 1, rx, ak);
         check({8'h00, rx}, {8'h00, mdl[reg_at(idx, k)]});
         check(16'(ak), 16'(k == n - 1));
      end
      host.bus_stop();
      check(16'(sda_oe), 16'h0000);
   endtask
   // ==========================================
   // Sequence
   task automatic complete_run();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      logic [15:0] s;
      s = rnd;
      for (int i = 0; i < 256; i++) begin
         s = lfsr(s);
         regs[i] = s[7:0];
         mdl[i] = s[7:0];
      end
      repeat (12) @(posedge clk);
      reset_n <= 1'b1;
      repeat (8) @(posedge clk);
      wr_seq(7'h5a, 8'h10, 4, 4, 1'b1);
      rd_seq(8'h10, 4);
      rd_seq(8'h12, 1);
      wr_seq(7'h5a, 8'hfe, 3, 3, 1'b1);
      rd_seq(8'hfe, 3);
      wr_seq(7'h2d, 8'h00, 1, 0, 1'b0);
      wr_seq(7'h58, 8'h20, 1, 0, 1'b0);
      bcast <= 1'b1;
      wr_seq(7'h58, 8'h20, 2, 2, 1'b1);
      // Receiver stalls: the two-entry buffer takes two words, refuses the third
      stall <= 1'b1;
      wr_seq(7'h5a, 8'h30, 3, 2, 1'b1);
      stall <= 1'b0;
      drain();
      rd_seq(8'h30, 2);
      for (int j = 0; j < 4; j++) begin
         s = rnd;
         wr_seq(7'h5a, s[7:0], int'(s[9:8]) + 1, int'(s[9:8]) + 1, 1'b1);
         rd_seq(s[7:0], int'(s[9:8]) + 1);
      end
      complete_run();
   end
   initial begin
      #400us;
      fail_count++;
      complete_run();
   end
endmodule
